/* npcs_sequencer.sv */
// The register addresses and strobed register access are this design's own decisions.
`include "npcs_defines.svh"
`default_nettype none
module npcs_sequencer
    import npcs_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [3:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [31:0]     reg_rdata,
    output logic            nand_cle,
    output logic            nand_ale,
    output logic            nand_ce_n,
    output logic            nand_we_n,
    output logic            nand_re_n,
    input  wire logic       nand_ready_busy,
    input  wire logic [7:0] nand_io_in,
    output logic [7:0]      nand_io_out,
    output logic            nand_io_oe
);
    typedef struct packed {
        npcs_state_type state;
        logic [2:0]  op;
        logic [23:0] addr;
        logic [23:0] tgt;
        logic [1:0]  acnt;
        logic [1:0]  anum;
        logic [9:0]  len;
        logic [9:0]  bcnt;
        logic        start;
        npcs_cyc_type kind;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        wpend;
        logic        busy;
        logic        err;
        logic        ce_n;
        logic [2:0]  ceh;
        logic [31:0] rd_out;
        logic        cbusy;
        logic [7:0]  pdata;
    } npcs_st_type;

    npcs_st_type st_r;
    npcs_st_type st_nxt;
    logic [7:0]  io_m_r;
    logic [7:0]  io_s_r;
    logic        rb_m_r;
    logic        rb_s_r;
    npcs_strobe_if cyc ();

    npcs_bus_cycle u_cycle (
        .core_clk (core_clk),
        .rstn     (rstn),
        .io_sync  (io_s_r),
        .bus      (cyc)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            io_m_r <= 8'h00;
            io_s_r <= 8'h00;
            rb_m_r <= 1'b0;
            rb_s_r <= 1'b0;
        end else begin
            io_m_r <= nand_io_in;
            io_s_r <= io_m_r;
            rb_m_r <= nand_ready_busy;
            rb_s_r <= rb_m_r;
        end
    end

    assign cyc.start = st_r.start;
    assign cyc.kind  = st_r.kind;
    assign cyc.wdata = st_r.wdata;

    function automatic logic [7:0] addr_byte(input logic [23:0] a, input logic [1:0] i);
        logic [7:0] b;
        b = 8'h00;
        unique case (i)
            2'h0: b = a[7:0];
            2'h1: b = a[15:8];
            2'h2: b = a[23:16];
            2'h3: b = 8'h00;
        endcase
        return b;
    endfunction

    always_comb begin
        st_nxt       = st_r;
        st_nxt.start = 1'b0;
        if (reg_wr && reg_addr == `NPCS_REG_ADDR) begin
            st_nxt.addr = reg_wdata[23:0];
            st_nxt.tgt  = {reg_wdata[23], reg_wdata[22:0]};
        end
        if (reg_wr && reg_addr == `NPCS_REG_LEN) begin
            st_nxt.len = reg_wdata[9:0];
        end
        if (reg_wr && reg_addr == `NPCS_REG_WDATA) begin
            st_nxt.pdata = reg_wdata[7:0];
            st_nxt.wpend = 1'b1;
        end
        if (reg_rd && reg_addr == `NPCS_REG_RDATA) begin
            st_nxt.rvalid = 1'b0;
        end
        if (cyc.done) begin
            st_nxt.cbusy = 1'b0;
        end
        unique case (st_r.state)
            NPCS_IDLE: begin
                st_nxt.busy = 1'b0;
                if (reg_wr && reg_addr == `NPCS_REG_CTRL && reg_wdata[2:0] != 3'h0) begin
                    st_nxt.op    = reg_wdata[2:0];
                    st_nxt.busy  = 1'b1;
                    st_nxt.rvalid = 1'b0;
                    st_nxt.ce_n  = 1'b0;
                    st_nxt.state = NPCS_CMD1;
                    if (reg_wdata[2:0] == `NPCS_OP_RDNEXT) begin
                        // Keep chip enable low and read on past the page edge
                        st_nxt.bcnt  = st_r.len;
                        st_nxt.state = NPCS_READ;
                    end
                end
            end
            NPCS_CMD1: begin
                st_nxt.start = 1'b1;
                st_nxt.kind  = NPCS_CYC_CMD;
                st_nxt.acnt  = 2'h0;
                st_nxt.anum  = 2'h3;
                st_nxt.bcnt  = st_r.len;
                unique case (st_r.op)
                    `NPCS_OP_PROG:   st_nxt.wdata = `NPCS_CMD_PROG_SETUP;
                    `NPCS_OP_ERASE: begin
                        st_nxt.wdata = `NPCS_CMD_ERASE_SETUP;
                        st_nxt.acnt  = 2'h1;
                    end
                    `NPCS_OP_STATUS: st_nxt.wdata = `NPCS_CMD_STATUS;
                    `NPCS_OP_RESET:  st_nxt.wdata = `NPCS_CMD_RESET;
                    default:         st_nxt.wdata = `NPCS_CMD_READ_A;
                endcase
                st_nxt.state = NPCS_CMD2;
                if (st_r.op == `NPCS_OP_STATUS || st_r.op == `NPCS_OP_RESET) begin
                    st_nxt.acnt = 2'h3;
                end
            end
            NPCS_CMD2: begin
                if (cyc.done) begin
                    st_nxt.state = (st_r.acnt == st_r.anum) ? NPCS_CMD3 : NPCS_ADDR;
                end
            end
            NPCS_ADDR: begin
                st_nxt.start = 1'b1;
                st_nxt.kind  = NPCS_CYC_ADDR;
                st_nxt.wdata = addr_byte(st_r.addr, st_r.acnt);
                st_nxt.acnt  = st_r.acnt + 2'h1;
                st_nxt.state = NPCS_CMD2;
            end
            NPCS_CMD3: begin
                unique case (st_r.op)
                    `NPCS_OP_PROG:  st_nxt.state = NPCS_DATA_W;
                    `NPCS_OP_ERASE: begin
                        st_nxt.start = 1'b1;
                        st_nxt.kind  = NPCS_CYC_CMD;
                        st_nxt.wdata = `NPCS_CMD_ERASE_CONF;
                        st_nxt.op    = `NPCS_OP_STATUS;
                        st_nxt.state = NPCS_WAIT_RB;
                    end
                    `NPCS_OP_STATUS: st_nxt.state = NPCS_READ;
                    default:         st_nxt.state = NPCS_WAIT_RB;
                endcase
            end
            NPCS_DATA_W: begin
                if (st_r.bcnt == 10'h000) begin
                    st_nxt.start = 1'b1;
                    st_nxt.kind  = NPCS_CYC_CMD;
                    st_nxt.wdata = `NPCS_CMD_PROG_CONF;  // One program per command
                    st_nxt.op    = `NPCS_OP_STATUS;
                    st_nxt.state = NPCS_WAIT_RB;
                end else if (st_r.wpend && !st_r.start) begin
                    st_nxt.start = 1'b1;
                    st_nxt.kind  = NPCS_CYC_WR;
                    st_nxt.wdata = st_r.pdata;
                    // A byte written in this same cycle stays pending
                    st_nxt.wpend = reg_wr && reg_addr == `NPCS_REG_WDATA;
                    st_nxt.bcnt  = st_r.bcnt - 10'h001;
                    st_nxt.state = NPCS_CMD2;
                    st_nxt.acnt  = 2'h3;
                    st_nxt.anum  = 2'h3;
                end
            end
            NPCS_WAIT_RB: begin
                // Dwell lets the busy drop pass the ready synchroniser first
                if (st_r.ceh != 3'h7) begin
                    st_nxt.ceh = st_r.ceh + 3'h1;
                end
                if (st_r.ceh == 3'h7 && !st_r.start && !cyc.done && cyc.we_n && rb_s_r) begin
                    st_nxt.ceh = 3'h0;
                    if (st_r.op == `NPCS_OP_COPY) begin
                        st_nxt.start = 1'b1;
                        st_nxt.kind  = NPCS_CYC_CMD;
                        st_nxt.wdata = `NPCS_CMD_COPY_2ND;
                        st_nxt.addr  = st_r.tgt;
                        st_nxt.op    = `NPCS_OP_PROG;
                        st_nxt.bcnt  = 10'h000;  // No data loaded into target
                        st_nxt.acnt  = 2'h0;
                        st_nxt.anum  = 2'h3;
                        st_nxt.state = NPCS_CMD2;
                    end else if (st_r.op == `NPCS_OP_STATUS) begin
                        st_nxt.start = 1'b1;
                        st_nxt.kind  = NPCS_CYC_CMD;
                        st_nxt.wdata = `NPCS_CMD_STATUS;
                        st_nxt.acnt  = 2'h3;
                        st_nxt.bcnt  = 10'h001;
                        st_nxt.rvalid = 1'b0;
                        st_nxt.state = NPCS_CMD2;
                    end else begin
                        st_nxt.state = (st_r.op == `NPCS_OP_READ) ? NPCS_READ : NPCS_CEH;
                    end
                end
            end
            NPCS_READ: begin
                if (cyc.done) begin
                    st_nxt.rdata  = cyc.rdata;
                    st_nxt.rvalid = 1'b1;
                    if (st_r.op == `NPCS_OP_STATUS) begin
                        st_nxt.err = cyc.rdata[`NPCS_SR_FAIL];
                    end
                end
                if (st_r.bcnt == 10'h000 && !st_r.start && !st_r.cbusy) begin
                    // Leave chip enable low so software can continue with op 7
                    st_nxt.busy  = 1'b0;
                    st_nxt.state = NPCS_IDLE;
                end else if (st_r.bcnt != 10'h000 && !st_r.start && !st_r.cbusy && !st_r.rvalid) begin
                    st_nxt.start = 1'b1;
                    st_nxt.cbusy = 1'b1;
                    st_nxt.kind  = NPCS_CYC_RD;
                    st_nxt.bcnt  = st_r.bcnt - 10'h001;
                end
            end
            NPCS_CEH: begin
                st_nxt.ce_n = 1'b1;
                st_nxt.ceh  = st_r.ceh + 3'h1;
                if (st_r.ceh == 3'(`NPCS_CEH_CYC)) begin
                    st_nxt.ceh   = 3'h0;
                    st_nxt.busy  = 1'b0;
                    st_nxt.state = NPCS_IDLE;
                end
            end
        endcase
        if (reg_wr && reg_addr == `NPCS_REG_CTRL && reg_wdata[3]) begin
            st_nxt.ceh   = 3'h0;
            st_nxt.state = NPCS_CEH;  // Ends a continuous read
        end
        st_nxt.rd_out = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                `NPCS_REG_ADDR:   st_nxt.rd_out = {8'h00, st_r.addr};
                `NPCS_REG_LEN:    st_nxt.rd_out = {22'h0, st_r.len};
                `NPCS_REG_STATUS: st_nxt.rd_out = {26'h0, rb_s_r, st_r.wpend,
                                                   st_r.rvalid, st_r.err, st_r.ce_n, st_r.busy};
                `NPCS_REG_RDATA:  st_nxt.rd_out = {24'h0, st_r.rdata};
                default:          st_nxt.rd_out = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{state: NPCS_IDLE, kind: NPCS_CYC_CMD, ce_n: 1'b1, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            nand_ce_n <= 1'b1;
        end else begin
            nand_ce_n <= st_nxt.ce_n;
        end
    end

    assign reg_rdata   = st_r.rd_out;
    assign nand_cle    = cyc.cle;
    assign nand_ale    = cyc.ale;
    assign nand_we_n   = cyc.we_n;
    assign nand_re_n   = cyc.re_n;
    assign nand_io_out = cyc.io_out;
    assign nand_io_oe  = cyc.io_oe;

    a_ceh_gap_len: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r.state == NPCS_CEH && st_r.ceh == 3'h0) |-> ##1 nand_ce_n [*4])
        else $error("chip enable high gap too short");
    a_erase_two_addr: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r.state == NPCS_CMD1 && st_r.op == `NPCS_OP_ERASE) |=> st_nxt.acnt == 2'h1)
        else $error("erase did not skip column cycle");
    a_wait_for_ready: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r.state == NPCS_WAIT_RB && st_nxt.state != NPCS_WAIT_RB) |-> rb_s_r)
        else $error("left wait before ready");
    a_ce_low_in_op: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r.state == NPCS_ADDR) |-> !nand_ce_n)
        else $error("chip enable high during address");
    a_rd_one_cycle: assert property (@(posedge core_clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_read_count: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r.state == NPCS_READ && st_nxt.start) |=> st_r.bcnt == $past(st_r.bcnt) - 10'h001)
        else $error("read count not advanced");
    a_prog_conf: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r.state == NPCS_DATA_W && st_r.bcnt == 10'h000) |=> st_r.wdata == `NPCS_CMD_PROG_CONF)
        else $error("program confirm missing");
    a_rst_code: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_r.state == NPCS_CMD1 && st_r.op == `NPCS_OP_RESET) |=> st_r.wdata == `NPCS_CMD_RESET)
        else $error("reset code wrong");
endmodule
`default_nettype wire

/* npcs_defines.svh */
`ifndef NPCS_DEFINES_SVH
`define NPCS_DEFINES_SVH
// Command codes
`define NPCS_CMD_READ_A      8'h00
`define NPCS_CMD_PROG_SETUP  8'h80
`define NPCS_CMD_PROG_CONF   8'h10
`define NPCS_CMD_COPY_2ND    8'h8a
`define NPCS_CMD_ERASE_SETUP 8'h60
`define NPCS_CMD_ERASE_CONF  8'hd0
`define NPCS_CMD_STATUS      8'h70
`define NPCS_CMD_RESET       8'hff
// Status byte fields
`define NPCS_SR_PROTECT_CLEAR 7
`define NPCS_SR_IDLE          6
`define NPCS_SR_IDLE_ALT      5
`define NPCS_SR_FAIL          0
// Software register offsets
`define NPCS_REG_CTRL   4'h0
`define NPCS_REG_ADDR   4'h1
`define NPCS_REG_WDATA  4'h2
`define NPCS_REG_STATUS 4'h3
`define NPCS_REG_RDATA  4'h4
`define NPCS_REG_LEN    4'h5
// Control op codes
`define NPCS_OP_READ    3'h1
`define NPCS_OP_PROG    3'h2
`define NPCS_OP_ERASE   3'h3
`define NPCS_OP_COPY    3'h4
`define NPCS_OP_STATUS  3'h5
`define NPCS_OP_RESET   3'h6
`define NPCS_OP_RDNEXT  3'h7
// Page geometry
`define NPCS_PAGE_BYTES 10'd528
// Timing: strobe phase 40 ns, chip-enable high gap 100 ns, at 20 ns clock
`define NPCS_CLK_NS      20
`define NPCS_PHASE_NS    40
`define NPCS_PHASE_CYC   ((`NPCS_PHASE_NS + `NPCS_CLK_NS - 1) / `NPCS_CLK_NS)
`define NPCS_CEH_NS      100
`define NPCS_CEH_CYC     ((`NPCS_CEH_NS + `NPCS_CLK_NS - 1) / `NPCS_CLK_NS + 1)
`endif

/* npcs_pkg.sv */
`default_nettype none
package npcs_pkg;
    typedef enum logic [3:0] {
        NPCS_IDLE, NPCS_CMD1, NPCS_ADDR, NPCS_DATA_W, NPCS_CMD2, NPCS_WAIT_RB,
        NPCS_CMD3, NPCS_READ, NPCS_CEH
    } npcs_state_type;
    typedef enum logic [1:0] {
        NPCS_CYC_CMD, NPCS_CYC_ADDR, NPCS_CYC_WR, NPCS_CYC_RD
    } npcs_cyc_type;
endpackage
`default_nettype wire

/* npcs_strobe_if.sv */
`default_nettype none
interface npcs_strobe_if;
    logic                      start;
    npcs_pkg::npcs_cyc_type    kind;
    logic [7:0]                wdata;
    logic                      done;
    logic [7:0]                rdata;
    logic                      cle;
    logic                      ale;
    logic                      we_n;
    logic                      re_n;
    logic                      io_oe;
    logic [7:0]                io_out;
    modport master (output start, output kind, output wdata,
                    input done, input rdata);
    modport engine (input start, input kind, input wdata,
                    output done, output rdata, output cle, output ale,
                    output we_n, output re_n, output io_oe, output io_out);
endinterface
`default_nettype wire

/* npcs_bus_cycle.sv */
`include "npcs_defines.svh"
`default_nettype none
module npcs_bus_cycle
    import npcs_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rstn,
    input  wire logic [7:0] io_sync,
    npcs_strobe_if.engine bus
);
    typedef struct packed {
        logic       busy;
        logic       phase;
        logic [1:0] cnt;
        npcs_cyc_type kind;
        logic       done;
        logic [7:0] rdata;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       re_n;
        logic       io_oe;
        logic [7:0] io_out;
    } npcs_cyc_st_type;

    npcs_cyc_st_type st_r;
    npcs_cyc_st_type st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (!st_r.busy) begin
            if (bus.start) begin
                st_nxt.busy   = 1'b1;
                st_nxt.phase  = 1'b0;
                st_nxt.cnt    = 2'(`NPCS_PHASE_CYC - 1);
                st_nxt.kind   = bus.kind;
                st_nxt.cle    = (bus.kind == NPCS_CYC_CMD);
                st_nxt.ale    = (bus.kind == NPCS_CYC_ADDR);
                st_nxt.io_oe  = (bus.kind != NPCS_CYC_RD);
                st_nxt.io_out = bus.wdata;
                st_nxt.we_n   = (bus.kind == NPCS_CYC_RD);
                st_nxt.re_n   = (bus.kind != NPCS_CYC_RD);
            end
        end else if (st_r.cnt != 2'h0) begin
            st_nxt.cnt = st_r.cnt - 2'h1;
        end else if (!st_r.phase) begin
            // Device latches on the rising write strobe
            st_nxt.phase = 1'b1;
            st_nxt.cnt   = 2'(`NPCS_PHASE_CYC - 1);
            st_nxt.we_n  = 1'b1;
            st_nxt.re_n  = 1'b1;
        end else begin
            // Sampled late: the pin passes two flops, so this is the low-phase value
            if (st_r.kind == NPCS_CYC_RD) begin
                st_nxt.rdata = io_sync;
            end
            st_nxt.busy  = 1'b0;
            st_nxt.done  = 1'b1;
            st_nxt.cle   = 1'b0;
            st_nxt.ale   = 1'b0;
            st_nxt.io_oe = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{busy: 1'b0, phase: 1'b0, cnt: 2'h0, kind: NPCS_CYC_CMD, done: 1'b0,
                      rdata: 8'h00, cle: 1'b0, ale: 1'b0, we_n: 1'b1, re_n: 1'b1,
                      io_oe: 1'b0, io_out: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.done   = st_r.done;
    assign bus.rdata  = st_r.rdata;
    assign bus.cle    = st_r.cle;
    assign bus.ale    = st_r.ale;
    assign bus.we_n   = st_r.we_n;
    assign bus.re_n   = st_r.re_n;
    assign bus.io_oe  = st_r.io_oe;
    assign bus.io_out = st_r.io_out;

    a_strobe_low_len: assert property (@(posedge core_clk) disable iff (!rstn)
        $fell(st_r.we_n) |-> !st_r.we_n [*2] ##1 st_r.we_n)
        else $error("write strobe low time wrong");
    a_cmd_latch_hold: assert property (@(posedge core_clk) disable iff (!rstn)
        ($rose(st_r.we_n) && st_r.cle) |-> st_r.io_oe)
        else $error("command data not driven at latch edge");
endmodule
`default_nettype wire

/* npcs_nand_model.sv */
`default_nettype none
module npcs_nand_model #(parameter int BUSY_CYC = 40) (
    input  wire logic       core_clk,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       ce_n,
    input  wire logic       we_n,
    input  wire logic       re_n,
    input  wire logic [7:0] io_w,
    input  wire logic       fail_next,
    output logic            rb,
    output logic [7:0]      io_r
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cmds[$];
    logic [7:0] addrs[$];
    int         data_cnt  = 0;
    int         busy_left = 0;
    int         acnt      = 0;
    int         col       = 0;
    logic       stat_mode = 1'b0;
    logic       fail      = 1'b0;
    logic       rd_pend   = 1'b0;
    logic [7:0] val;
    assign rb = (busy_left == 0); // Ready again after program
    always @(posedge core_clk) if (busy_left > 0) busy_left <= busy_left - 1;
    always @(posedge we_n) begin
        if (!ce_n && cle && (rb || io_w == 8'h70 || io_w == 8'hff)) begin
            cmds.push_back(io_w);
            acnt = 0;
            case (io_w)
                8'h70: stat_mode = 1'b1;
                8'hff: begin
                    stat_mode = 1'b0;
                    fail = 1'b0;
                    busy_left = 3;
                end
                8'h10, 8'hd0: begin
                    fail = fail_next;
                    busy_left = BUSY_CYC;
                end
                8'h00: begin
                    stat_mode = 1'b0;
                    rd_pend = 1'b1;
                    col = 0;
                end
                default: ; // Other codes change nothing
            endcase
        end else if (!ce_n && ale) begin
            addrs.push_back(io_w);
            acnt++;
            if (rd_pend && acnt == 3) begin
                rd_pend = 1'b0;
                busy_left = BUSY_CYC / 4; // Page load into buffer
            end
        end else if (!ce_n) data_cnt++;
    end
    always @(posedge re_n) if (!ce_n && !stat_mode) col++; // Next page follows on
    always_comb val = stat_mode ? {1'b1, rb, rb, 4'h0, fail} : col[7:0];
    // Released bus shows the inverse of the read value, never the value itself
    always_comb io_r = (!ce_n && !re_n) ? val : ~val;
endmodule
`default_nettype wire

/* tb.sv */
`include "npcs_defines.svh"
`default_nettype none
module tb;
    import npcs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fail_next = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic        cle, ale, ce_n, we_n, re_n, rb, oe;
    logic [7:0]  io_out, io_r, io_w;
    int          fails = 0, checks = 0;
    assign io_w = oe ? io_out : io_r;
    npcs_sequencer dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .nand_cle(cle), .nand_ale(ale), .nand_ce_n(ce_n), .nand_we_n(we_n), .nand_re_n(re_n),
        .nand_ready_busy(rb), .nand_io_in(io_w), .nand_io_out(io_out), .nand_io_oe(oe));
    npcs_nand_model #(.BUSY_CYC(40)) model_u (.core_clk(core_clk), .cle(cle), .ale(ale),
        .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .io_w(io_w), .fail_next(fail_next), .rb(rb),
        .io_r(io_r));
    initial forever #10 core_clk = ~core_clk;
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_q(ref logic [7:0] q[$], input logic [7:0] exp[$]);
        chk(q.size(), exp.size());
        foreach (exp[k]) chk(32'(q[k]), 32'(exp[k]));
        q.delete();
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_bit(input int b, input logic lvl);
        for (int i = 0; i < 3000; i++) begin
            rd(`NPCS_REG_STATUS, v);
            if (v[b] === lvl) return;
        end
        fails++;
        end_sim();
    endtask
    initial begin
        #1900000;
        fails++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        rd(`NPCS_REG_STATUS, v);
        chk(32'(v[1:0]), 32'h2);
        rd(4'hf, v);
        chk(v, 32'h0);
        for (int f = 0; f < 2; f++) begin
            fail_next <= f[0];
            wr(`NPCS_REG_LEN, 32'h3);
            wr(`NPCS_REG_ADDR, 32'h00123456 + 32'(f << 8)); // Fresh page each pass
            wr(`NPCS_REG_CTRL, 32'(`NPCS_OP_PROG));
            for (int k = 0; k < 3; k++) begin
                wait_bit(4, 1'b0);
                wr(`NPCS_REG_WDATA, 32'ha0 + 32'(k));
            end
            wait_bit(0, 1'b0);
            chk_q(model_u.cmds, '{8'h80, 8'h10, 8'h70});
            chk_q(model_u.addrs, '{8'h56, 8'(8'h34 + f), 8'h12});
            chk(model_u.data_cnt, 32'(3 * (f + 1)));
            rd(`NPCS_REG_STATUS, v);
            chk(32'(v[2]), 32'(f));
        end
        wr(`NPCS_REG_ADDR, 32'h00123400);
        wr(`NPCS_REG_CTRL, 32'(`NPCS_OP_ERASE));
        wait_bit(0, 1'b0);
        chk_q(model_u.cmds, '{8'h60, 8'hd0, 8'h70});
        chk_q(model_u.addrs, '{8'h34, 8'h12});
        wr(`NPCS_REG_ADDR, 32'h00125600); // Target equals source, same top bit
        wr(`NPCS_REG_CTRL, 32'(`NPCS_OP_COPY));
        wait_bit(0, 1'b0);
        chk_q(model_u.cmds, '{8'h00, 8'h8a, 8'h10, 8'h70});
        chk_q(model_u.addrs, '{8'h00, 8'h56, 8'h12, 8'h00, 8'h56, 8'h12});
        wr(`NPCS_REG_CTRL, 32'(`NPCS_OP_RESET));
        wait_bit(0, 1'b0);
        chk_q(model_u.cmds, '{8'hff});
        wr(`NPCS_REG_CTRL, 32'(`NPCS_OP_STATUS));
        for (int k = 0; k < 2; k++) begin
            wait_bit(3, 1'b1);
            rd(`NPCS_REG_RDATA, v);
            chk(32'(v[7:0]), 32'he0);
        end
        wr(`NPCS_REG_CTRL, 32'h8);
        wait_bit(0, 1'b0);
        model_u.cmds.delete();
        model_u.addrs.delete();
        wr(`NPCS_REG_ADDR, 32'h00120000); // Stays inside one block
        wr(`NPCS_REG_CTRL, 32'(`NPCS_OP_READ));
        for (int k = 0; k < 3; k++) begin
            wait_bit(3, 1'b1);
            rd(`NPCS_REG_RDATA, v);
            chk(32'(v[7:0]), 32'(k));
        end
        wr(`NPCS_REG_CTRL, 32'h8);
        wait_bit(1, 1'b1);
        chk(32'(ce_n), 32'h1);
        chk_q(model_u.cmds, '{8'h00});
        end_sim();
    end
endmodule
`default_nettype wire
